// file: hw/sgs_pkg.sv
// Purpose: constants and types of the parameter group selector
// Assumes: one clock, avalon-mm register access
// Notes: group index 0..7 stands for groups 1..8
package sgs_pkg;
    localparam int unsigned NGRP        = 8;
    localparam logic [4:0]  OFS_CTRL    = 5'h00;
    localparam logic [4:0]  OFS_MODE    = 5'h04;
    localparam logic [4:0]  OFS_FORCE   = 5'h08;
    localparam logic [4:0]  OFS_REMOTE  = 5'h0c;
    localparam logic [4:0]  OFS_LOCAL   = 5'h10;
    localparam logic [4:0]  OFS_STATUS  = 5'h14;
    localparam logic [4:0]  OFS_EVENTS  = 5'h18;
    localparam int unsigned CTRL_OVR    = 0;
    localparam int unsigned CTRL_USED_L = 4;
    localparam logic [2:0]  USED_RST    = 3'h1;
    localparam logic [2:0]  ACTIVE_RST  = 3'h0;
    localparam logic [7:0]  MODE_RST    = 8'h00;
    localparam logic [3:0]  SEL_NONE    = 4'h0;

    typedef struct packed {
        logic        read;
        logic        write;
        logic [4:0]  address;
        logic [31:0] writedata;
    } sgs_av_req_t;

    typedef struct packed {
        logic grp_enabled;
        logic grp_disabled;
        logic req_on;
        logic req_off;
        logic remote_chg;
        logic local_chg;
        logic force_chg;
        logic fail_unconf;
        logic fail_force;
        logic fail_lower;
        logic active_chg;
    } sgs_evt_t;

    localparam int unsigned EVT_W = $bits(sgs_evt_t);
endpackage : sgs_pkg

// file: hw/sgs_selector.sv
// Purpose: parameter group selection with fixed priority and override
// Assumes: request inputs synchronous to clk_sys
// Notes: registers over avalon-mm, one wait state per access
`timescale 1ns/1ps
module sgs_selector #(
    parameter int unsigned NG = sgs_pkg::NGRP
) (
    input  wire logic                      clk_sys,
    input  wire logic                      arst_n,
    input  wire sgs_pkg::sgs_av_req_t      av_req,
    output logic [31:0]                    av_readdata,
    output logic                           av_waitrequest,
    input  wire logic [NG-1:0]             grp_req_in,
    output logic [2:0]                     active_group,
    output logic [NG-1:0]                  active_onehot,
    output sgs_pkg::sgs_evt_t              evt_pulse
);
    function automatic logic [2:0] first_idx(input logic [7:0] v);
        logic [2:0] r;
        r = 3'h0;
        for (int i = 7; i >= 0; i--) begin
            if (v[i]) begin
                r = 3'(i);
            end
        end
        return r;
    endfunction : first_idx

    function automatic logic [7:0] sel_onehot(input logic [3:0] s);
        logic [7:0] r;
        r = 8'h00;
        if (s != sgs_pkg::SEL_NONE && s <= 4'h8) begin
            r[3'(s - 4'h1)] = 1'b1;
        end
        return r;
    endfunction : sel_onehot

    // bits of all groups of lower priority than the highest one held
    function automatic logic [7:0] below_first(input logic [7:0] v);
        logic [7:0] r;
        logic       seen;
        r    = 8'h00;
        seen = 1'b0;
        for (int i = 0; i < 8; i++) begin
            r[i] = seen;
            seen = seen | v[i];
        end
        return r;
    endfunction : below_first

    localparam int unsigned EVT_W = sgs_pkg::EVT_W;

    logic              ack_reg;
    logic [31:0]       rdata_reg;
    logic              ovr_reg;
    logic [2:0]        used_reg;
    logic [7:0]        mode_reg;
    logic [3:0]        force_reg;
    logic [3:0]        remote_reg;
    logic [3:0]        local_reg;
    logic [2:0]        active_reg;
    logic [2:0]        active_next;
    logic [7:0]        req_d_reg;
    logic              multi_d_reg;
    logic              ovr_d_reg;
    logic [7:0]        en_d_reg;
    logic [EVT_W-1:0]  sticky_reg;
    sgs_pkg::sgs_evt_t evt_reg;
    sgs_pkg::sgs_evt_t evt_next;

    wire        acc      = av_req.read | av_req.write;
    wire        wr_go    = av_req.write & ack_reg;
    wire        rd_load  = av_req.read & ~ack_reg;
    wire [3:0]  wsel     = av_req.writedata[3:0];
    wire        wr_ctrl  = wr_go && av_req.address == sgs_pkg::OFS_CTRL;
    wire        wr_mode  = wr_go && av_req.address == sgs_pkg::OFS_MODE;
    wire        wr_force = wr_go && av_req.address == sgs_pkg::OFS_FORCE;
    wire        wr_rem   = wr_go && av_req.address == sgs_pkg::OFS_REMOTE;
    wire        wr_loc   = wr_go && av_req.address == sgs_pkg::OFS_LOCAL;
    wire        wr_evt   = wr_go && av_req.address == sgs_pkg::OFS_EVENTS;
    wire [2:0]  used_wr  = av_req.writedata[sgs_pkg::CTRL_USED_L +: 3];

    // a zero count falls back to one group
    wire [2:0]  used_n   = (used_reg == 3'h0) ? 3'h1 : used_reg;
    wire [7:0]  en_mask  = 8'((9'h001 << used_n) - 9'h001);
    wire        multi    = used_n > 3'h1;

    wire [7:0]  req      = grp_req_in;
    wire [7:0]  rise     = req & ~req_d_reg;
    wire [7:0]  fall     = ~req & req_d_reg;
    wire [7:0]  lvl_held = req & mode_reg & en_mask;
    // held levels are re-applied when the logic wakes or override drops
    wire        reapply  = (multi & ~multi_d_reg) | (~ovr_reg & ovr_d_reg);
    wire [7:0]  lvl_app  = reapply ? lvl_held : (rise & mode_reg);
    wire [7:0]  pls_app  = rise & ~mode_reg;
    wire [7:0]  rem_oh   = wr_rem ? sel_onehot(wsel) : 8'h00;
    wire [7:0]  loc_oh   = wr_loc ? sel_onehot(wsel) : 8'h00;
    wire [7:0]  cand_raw = lvl_app | pls_app | rem_oh | loc_oh;
    wire [7:0]  blocked  = below_first(lvl_held);
    wire [7:0]  cand     = cand_raw & en_mask & ~blocked;
    wire        auto_ok  = multi & ~ovr_reg & (|cand);
    wire [2:0]  winner   = first_idx(cand);
    wire [7:0]  frc_oh   = wr_force ? sel_onehot(wsel) : 8'h00;
    wire        frc_ok   = multi & ovr_reg & (|(frc_oh & en_mask));
    wire        frc_bad  = (|frc_oh) & ~ovr_reg;
    wire        man_bad  = ovr_reg & (wr_rem | wr_loc);
    wire        unconf   = |((cand_raw | frc_oh) & ~en_mask);
    wire        lower    = ~ovr_reg & (|(cand_raw & en_mask & blocked));

    always_comb begin
        active_next = active_reg;
        if (!multi) begin
            active_next = sgs_pkg::ACTIVE_RST;
        end else if (frc_ok) begin
            active_next = first_idx(frc_oh);
        end else if (auto_ok) begin
            active_next = winner;
        end else if (!en_mask[active_reg]) begin
            active_next = sgs_pkg::ACTIVE_RST;
        end
        // no new request leaves the last group in place, forced or not, while that group stays enabled
    end

    always_comb begin
        evt_next              = '0;
        evt_next.grp_enabled  = |(en_mask & ~en_d_reg);
        evt_next.grp_disabled = |(~en_mask & en_d_reg);
        evt_next.req_on       = |rise;
        evt_next.req_off      = |fall;
        evt_next.remote_chg   = wr_rem & auto_ok & (|(rem_oh & cand));
        evt_next.local_chg    = wr_loc & auto_ok & (|(loc_oh & cand));
        evt_next.force_chg    = frc_ok;
        evt_next.fail_unconf  = unconf;
        evt_next.fail_force   = frc_bad | man_bad;
        evt_next.fail_lower   = lower;
        evt_next.active_chg   = active_next != active_reg;
    end

    wire [31:0] status_w = {8'h00, en_mask, lvl_held, 5'h00, active_reg};
    wire [31:0] ctrl_w   = {25'h0, used_n, 3'h0, ovr_reg};
    wire [31:0] rd_mux   =
        (av_req.address == sgs_pkg::OFS_CTRL)   ? ctrl_w :
        (av_req.address == sgs_pkg::OFS_MODE)   ? {24'h0, mode_reg} :
        (av_req.address == sgs_pkg::OFS_FORCE)  ? {28'h0, force_reg} :
        (av_req.address == sgs_pkg::OFS_REMOTE) ? {28'h0, remote_reg} :
        (av_req.address == sgs_pkg::OFS_LOCAL)  ? {28'h0, local_reg} :
        (av_req.address == sgs_pkg::OFS_STATUS) ? status_w :
        (av_req.address == sgs_pkg::OFS_EVENTS) ? 32'(sticky_reg) : 32'h0;
    // set beats clear for sticky event bits
    wire [EVT_W-1:0] clr_w  = wr_evt ? av_req.writedata[EVT_W-1:0] : '0;
    wire [EVT_W-1:0] stk_nx = (sticky_reg & ~clr_w) | evt_next;

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ack_reg   <= 1'b0;
            rdata_reg <= 32'h0;
        end else begin
            ack_reg   <= acc & ~ack_reg;
            rdata_reg <= rd_load ? rd_mux : rdata_reg;
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            ovr_reg    <= 1'b0;
            used_reg   <= sgs_pkg::USED_RST;
            mode_reg   <= sgs_pkg::MODE_RST;
            force_reg  <= sgs_pkg::SEL_NONE;
            remote_reg <= sgs_pkg::SEL_NONE;
            local_reg  <= sgs_pkg::SEL_NONE;
        end else begin
            if (wr_ctrl) begin
                ovr_reg  <= av_req.writedata[sgs_pkg::CTRL_OVR];
                used_reg <= used_wr;
            end
            if (wr_mode) begin
                mode_reg <= av_req.writedata[7:0];
            end
            if (wr_force) begin
                force_reg <= wsel;
            end
            if (wr_rem) begin
                remote_reg <= wsel;
            end
            if (wr_loc) begin
                local_reg <= wsel;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge arst_n) begin
        if (!arst_n) begin
            active_reg  <= sgs_pkg::ACTIVE_RST;
            req_d_reg   <= 8'h00;
            multi_d_reg <= 1'b0;
            ovr_d_reg   <= 1'b0;
            en_d_reg    <= 8'h01;
            evt_reg     <= '0;
            sticky_reg  <= '0;
        end else begin
            active_reg  <= active_next;
            req_d_reg   <= req;
            multi_d_reg <= multi;
            ovr_d_reg   <= ovr_reg;
            en_d_reg    <= en_mask;
            evt_reg     <= evt_next;
            sticky_reg  <= stk_nx;
        end
    end

    assign av_waitrequest = acc & ~ack_reg;
    assign av_readdata    = rdata_reg;
    assign active_group   = active_reg;
    assign active_onehot  = NG'(8'h01 << active_reg);
    assign evt_pulse      = evt_reg;

    property p_idle;
        @(posedge clk_sys) disable iff (!arst_n)
        !multi |=> active_reg == 3'h0;
    endproperty
    a_idle: assert property (p_idle) else $error("idle selector left group 1");

    property p_onehot;
        @(posedge clk_sys) disable iff (!arst_n)
        $onehot(active_onehot) && active_onehot[active_group];
    endproperty
    a_onehot: assert property (p_onehot) else $error("active group not one-hot");

    property p_override;
        @(posedge clk_sys) disable iff (!arst_n)
        multi && ovr_reg && !wr_force && en_mask[active_reg] |=> $stable(active_reg);
    endproperty
    a_override: assert property (p_override) else $error("group moved under override");

    property p_force;
        @(posedge clk_sys) disable iff (!arst_n)
        multi && ovr_reg && wr_force && wsel != 4'h0 && wsel <= {1'b0, used_n}
            |=> active_reg == $past(3'(wsel - 4'h1));
    endproperty
    a_force: assert property (p_force) else $error("forced group not applied");

    property p_grp1_level;
        @(posedge clk_sys) disable iff (!arst_n)
        multi && !ovr_reg && lvl_held[0] && active_reg == 3'h0 |=> active_reg == 3'h0;
    endproperty
    a_grp1_level: assert property (p_grp1_level) else $error("group 1 level lost");

    property p_hold;
        @(posedge clk_sys) disable iff (!arst_n)
        multi && cand_raw == 8'h00 && !wr_force && !reapply && en_mask[active_reg]
            ##1 !wr_force && cand_raw == 8'h00 |=> $stable(active_reg);
    endproperty
    a_hold: assert property (p_hold) else $error("group changed with no request");

    property p_reclaim;
        @(posedge clk_sys) disable iff (!arst_n)
        multi && $fell(ovr_reg) && lvl_held != 8'h00 && !wr_force
            |=> active_reg == first_idx($past(cand));
    endproperty
    a_reclaim: assert property (p_reclaim) else $error("level did not retake control");

    property p_unconf;
        @(posedge clk_sys) disable iff (!arst_n)
        wr_rem && (rem_oh & en_mask) == 8'h00 && rem_oh != 8'h00 |-> evt_next.fail_unconf
            ##1 evt_pulse.fail_unconf;
    endproperty
    a_unconf: assert property (p_unconf) else $error("unconfigured request not flagged");

    property p_prio;
        @(posedge clk_sys) disable iff (!arst_n)
        auto_ok && !frc_ok && cand[0] |=> active_reg == 3'h0;
    endproperty
    a_prio: assert property (p_prio) else $error("group 1 request lost priority");

    c_force: cover property (@(posedge clk_sys) disable iff (!arst_n) frc_ok);
    c_block: cover property (@(posedge clk_sys) disable iff (!arst_n) lower ##1 evt_pulse.fail_lower);
    c_reclaim: cover property (@(posedge clk_sys) disable iff (!arst_n)
        $fell(ovr_reg) && lvl_held != 8'h00);
    c_remote: cover property (@(posedge clk_sys) disable iff (!arst_n) evt_next.remote_chg);
endmodule : sgs_selector

// file: verif/sgs_req_model.sv
// Purpose: request sources on the far side of the selector
// Assumes: driven just after the rising edge of clk_sys
// Notes: a pulse lasts one clock, levels stay until changed
`timescale 1ns/1ps
module sgs_req_model (
    input  wire logic       clk_sys,
    output logic [7:0]      grp_req_in
);
    logic [7:0] lvl_reg;

    initial begin
        lvl_reg    = 8'h00;
        grp_req_in = 8'h00;
    end

    // one line per group, from logic or inputs
    task automatic set_level(input logic [7:0] m);
        @(posedge clk_sys);
        lvl_reg    <= m;
        grp_req_in <= m;
    endtask : set_level

    // pulse rides on top of held levels so they never drop
    task automatic pulse(input logic [7:0] m);
        @(posedge clk_sys);
        grp_req_in <= lvl_reg | m;
        @(posedge clk_sys);
        grp_req_in <= lvl_reg;
    endtask : pulse
endmodule : sgs_req_model

// file: verif/testbench.sv
// Purpose: self-checking bench of the group selector
// Assumes: one wait state per bus access, 1 cycle request latency
// Notes: group 8 cannot be enabled, so its level case is not run
`timescale 1ns/1ps
module testbench;
    logic                 clk_sys;
    logic                 arst_n;
    sgs_pkg::sgs_av_req_t av_req;
    logic [31:0]          av_readdata;
    logic                 av_waitrequest;
    logic [7:0]           grp_req_in;
    logic [2:0]           active_group;
    logic [7:0]           active_onehot;
    sgs_pkg::sgs_evt_t    evt_pulse;
    int                   n_errors;
    int                   comparisons;
    logic [31:0]          rd;

    sgs_selector sgs_selector_inst (
        .clk_sys        (clk_sys),
        .arst_n         (arst_n),
        .av_req         (av_req),
        .av_readdata    (av_readdata),
        .av_waitrequest (av_waitrequest),
        .grp_req_in     (grp_req_in),
        .active_group   (active_group),
        .active_onehot  (active_onehot),
        .evt_pulse      (evt_pulse)
    );

    sgs_req_model sgs_req_model_inst (
        .clk_sys    (clk_sys),
        .grp_req_in (grp_req_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        comparisons++;
        if (g !== e) begin
            n_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    // waitrequest read right after the rise still shows its pre-edge value
    task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
        int i;
        i = 0;
        @(posedge clk_sys);
        av_req <= '{read: ~wr, write: wr, address: a, writedata: d};
        do begin
            @(posedge clk_sys);
            i++;
        end while (av_waitrequest !== 1'b0 && i < 50);
        if (i >= 50) chk("bus_wait", 32'h0, 32'h1);
        rd = av_readdata;
        av_req <= '0;
    endtask : bus

    task automatic settle;
        repeat (3) @(posedge clk_sys);
        @(negedge clk_sys);
    endtask : settle

    task automatic act(input logic [2:0] e);
        settle;
        chk("active_group", {29'h0, e}, {29'h0, active_group});
        chk("active_onehot", 32'h1 << e, {24'h0, active_onehot});
    endtask : act

    task automatic t_reset;
        act(3'h0);
        sgs_req_model_inst.pulse(8'h02);
        act(3'h0);
        bus(1'b0, sgs_pkg::OFS_STATUS, 32'h0);
        chk("status", 32'h0001_0000, rd);
        bus(1'b0, 5'h1c, 32'h0);
        chk("unmapped", 32'h0, rd);
    endtask : t_reset

    task automatic t_pulse;
        bus(1'b1, sgs_pkg::OFS_CTRL, 32'h40);
        bus(1'b0, sgs_pkg::OFS_STATUS, 32'h0);
        chk("status_en", 32'h000f_0000, rd);
        bus(1'b1, sgs_pkg::OFS_EVENTS, 32'h7ff);
        bus(1'b0, sgs_pkg::OFS_EVENTS, 32'h0);
        chk("events_clr", 32'h0, rd);
        sgs_req_model_inst.pulse(8'h04);
        act(3'h2);
        bus(1'b0, sgs_pkg::OFS_EVENTS, 32'h0);
        chk("events_pulse", 32'h181, rd);
        sgs_req_model_inst.pulse(8'h0a);
        act(3'h1);
        sgs_req_model_inst.pulse(8'h10);
        act(3'h1);
        bus(1'b0, sgs_pkg::OFS_EVENTS, 32'h0);
        chk("fail_unconf", 32'h1, {31'h0, rd[3]});
    endtask : t_pulse

    task automatic t_level;
        bus(1'b1, sgs_pkg::OFS_MODE, 32'h0f);
        sgs_req_model_inst.set_level(8'h02);
        act(3'h1);
        sgs_req_model_inst.pulse(8'h04);
        act(3'h1);
        sgs_req_model_inst.pulse(8'h01);
        act(3'h0);
        sgs_req_model_inst.set_level(8'h00);
        sgs_req_model_inst.set_level(8'h03);
        act(3'h0);
        sgs_req_model_inst.set_level(8'h01);
        bus(1'b1, sgs_pkg::OFS_REMOTE, 32'h2);
        act(3'h0);
        bus(1'b0, sgs_pkg::OFS_EVENTS, 32'h0);
        chk("fail_lower", 32'h1, {31'h0, rd[1]});
    endtask : t_level

    task automatic t_force;
        sgs_req_model_inst.set_level(8'h00);
        bus(1'b1, sgs_pkg::OFS_CTRL, 32'h41);
        sgs_req_model_inst.pulse(8'h08);
        act(3'h0);
        bus(1'b1, sgs_pkg::OFS_FORCE, 32'h3);
        act(3'h2);
        bus(1'b1, sgs_pkg::OFS_FORCE, 32'h6);
        act(3'h2);
        bus(1'b1, sgs_pkg::OFS_CTRL, 32'h40);
        act(3'h2);
        bus(1'b1, sgs_pkg::OFS_CTRL, 32'h41);
        sgs_req_model_inst.set_level(8'h02);
        act(3'h2);
        bus(1'b1, sgs_pkg::OFS_CTRL, 32'h40);
        act(3'h1);
        bus(1'b1, sgs_pkg::OFS_FORCE, 32'h1);
        act(3'h1);
        bus(1'b0, sgs_pkg::OFS_EVENTS, 32'h0);
        chk("fail_force", 32'h1, {31'h0, rd[2]});
    endtask : t_force

    task automatic print_verdict;
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask : print_verdict

    initial begin
        n_errors    = 0;
        comparisons = 0;
        arst_n      = 1'b0;
        av_req      = '0;
        repeat (3) @(posedge clk_sys);
        arst_n <= 1'b1;
        t_reset;
        t_pulse;
        t_level;
        t_force;
        print_verdict;
    end

    // whole run needs well under a thousand cycles
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_errors++;
        print_verdict;
    end
endmodule : testbench
